// ==== tmc_hart_model.sv ====
// Behavioural hart pipeline that offers one access on the match port.
// Assumes access() is entered just after a rising clock edge.
`timescale 1ns/1ps
module tmc_hart_model #(
  parameter int NATIVE_REGISTER_WIDTH = 32
) (
  input wire logic clk,
  output logic op_valid,
  output logic [2:0] op_kind,
  output logic [1:0] op_priv,
  output logic [NATIVE_REGISTER_WIDTH-1:0] op_addr,
  output logic [NATIVE_REGISTER_WIDTH-1:0] op_data,
  output logic [1:0] op_size
);
  localparam int NW = NATIVE_REGISTER_WIDTH;

  initial begin
    op_valid = 1'b0;
    op_kind = 3'h0;
    op_priv = 2'h3;
    op_addr = {NW{1'b0}};
    op_data = {NW{1'b0}};
    op_size = 2'h0;
  end

  // Kind bits: [0] execute, [1] store, [2] load
  task automatic access(input logic [2:0] k, input logic [1:0] p, input logic [NW-1:0] a,
                        input logic [NW-1:0] d, input logic [1:0] s);
    op_valid <= 1'b1;
    op_kind <= k;
    op_priv <= p;
    op_addr <= a;
    op_data <= d;
    op_size <= s;
    @(posedge clk);
    op_valid <= 1'b0;
    op_kind <= 3'h0;
    // Idle buses carry the inverse so a stale value never looks valid
    op_addr <= ~a;
    op_data <= ~d;
  endtask : access
endmodule : tmc_hart_model

// ==== tmc_pkg.sv ====
// Constants shared by the trigger match and chain block.
// Assumes a 32-bit AHB-Lite register bus and a hart that presents one access per cycle.
package tmc_pkg;
  // Register byte offsets within the block's 4 KiB window
  localparam logic [11:0] TMC_HIT_OFS = 12'h000;
  localparam logic [11:0] TMC_LAST_OFS = 12'h004;
  localparam logic [3:0] TMC_TRIG_PAGE = 4'h1;
  localparam int TMC_TRIG_IDX_LSB = 3;
  localparam int TMC_TRIG_WORD_BIT = 2;
  localparam int TMC_LAST_ACT_LSB = 8;

  // Control word field layout
  localparam int TMC_CTRL_W = 17;
  localparam int TMC_ACT_LSB = 0;
  localparam int TMC_ACT_W = 4;
  localparam int TMC_CHAIN_BIT = 4;
  localparam int TMC_MODE_LSB = 5;
  localparam int TMC_MODE_W = 4;
  localparam int TMC_M_BIT = 9;
  localparam int TMC_S_BIT = 10;
  localparam int TMC_U_BIT = 11;
  localparam int TMC_EXEC_BIT = 12;
  localparam int TMC_STORE_BIT = 13;
  localparam int TMC_LOAD_BIT = 14;
  localparam int TMC_DMODE_BIT = 15;
  localparam int TMC_SEL_BIT = 16;
  localparam logic [TMC_CTRL_W-1:0] TMC_CTRL_RESET = 17'h00000;

  // Highest legal action code; larger writes legalize to zero
  localparam logic [3:0] TMC_ACT_MAX = 4'h1;

  typedef enum logic [3:0] {
    TMC_MODE_EQ = 4'h0,
    TMC_MODE_NAPOT = 4'h1,
    TMC_MODE_GE = 4'h2,
    TMC_MODE_LT = 4'h3,
    TMC_MODE_MLO = 4'h4,
    TMC_MODE_MHI = 4'h5,
    TMC_MODE_NEQ = 4'h8,
    TMC_MODE_NNAPOT = 4'h9,
    TMC_MODE_NMLO = 4'hc,
    TMC_MODE_NMHI = 4'hd
  } tmc_mode_t;

  localparam logic [1:0] TMC_PRIV_U = 2'h0;
  localparam logic [1:0] TMC_PRIV_S = 2'h1;
  localparam logic [1:0] TMC_PRIV_M = 2'h3;

  // Data access size codes: any, 8, 16 bits
  localparam logic [1:0] TMC_SIZE_ANY = 2'h0;
  localparam logic [1:0] TMC_SIZE_8 = 2'h1;
  localparam logic [1:0] TMC_SIZE_16 = 2'h2;

  typedef enum logic [2:0] {
    TMC_BUS_IDLE = 3'b001,
    TMC_BUS_WR = 3'b010,
    TMC_BUS_RD = 3'b100
  } tmc_bus_t;
endpackage : tmc_pkg

// ==== tmc_trigger_match.sv ====
// Trigger match and chain logic with its AHB-Lite register slave.
// Assumes the hart offers one access per cycle on OP_* and takes FIRE a cycle later.
// Notes on behaviour
// - Action field is legalized, resets to zero
// - Chained non-matching trigger blocks the next
// - Chain runs to next trigger with chain clear
// - Only last action taken, all must match
// - Debug-only cleared write zeroes chain if needed
// - Drop debug-only write breaking previous chain
// - Over-long chain forces chain bit zero
// - Equality mode matches exact compare value
// - NAPOT compares bits above lowest zero
// - Modes 2 and 3: unsigned ge, lt
// - Mode 4: low half masked compare
// - Mode 5: high half masked compare
// - Modes 8,9,12,13 invert; others reserved
// - Data compares use only low N bits
// - Machine enable allows match in machine mode
// - Absent S or U enables read zero
// - Execute qualifier checks fetched address or opcode
// - Store and load qualifiers check accesses
// - Select picks address or data comparison
//
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module tmc_trigger_match #(
  parameter int NTRIG = 4,
  parameter int NATIVE_REGISTER_WIDTH = 32,
  parameter bit HAS_S = 1'b1,
  parameter bit HAS_U = 1'b1,
  parameter int MAX_CHAIN = 4
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  input wire logic OP_VALID,
  input wire logic OP_EXEC,
  input wire logic OP_LOAD,
  input wire logic OP_STORE,
  input wire logic [1:0] PRIV,
  input wire logic [NATIVE_REGISTER_WIDTH-1:0] OP_ADDR,
  input wire logic [NATIVE_REGISTER_WIDTH-1:0] OP_DATA,
  input wire logic [1:0] OP_SIZE,
  output logic FIRE,
  output logic [3:0] FIRE_ACTION,
  output logic [$clog2(NTRIG)-1:0] FIRE_INDEX
);
  localparam int IW = $clog2(NTRIG);
  localparam int CW = tmc_pkg::TMC_CTRL_W;
  localparam int NW = NATIVE_REGISTER_WIDTH;
  localparam int HW = NW / 2;

  typedef struct packed {
    tmc_pkg::tmc_bus_t bus;
    logic [11:0] addr;
    logic hready;
    logic [31:0] hrdata;
    logic [NTRIG-1:0][CW-1:0] ctrl;
    logic [NTRIG-1:0][NW-1:0] cmp;
    logic [NTRIG-1:0] hit;
    logic fire;
    logic [3:0] fire_act;
    logic [IW-1:0] fire_idx;
  } tmc_state_t;

  tmc_state_t st_reg;
  tmc_state_t st_next;
  logic [NTRIG-1:0] elig;
  logic [NTRIG-1:0] raw;
  logic [NTRIG-1:0] ok;
  logic [NTRIG-1:0] ends;
  logic wr_ctrl;
  logic wr_cmp;
  logic [4:0] widx;

  // Base comparison on mode[2:0]; mode[3] inverts the result
  function automatic logic hit_fn(input logic [3:0] mode, input logic [NW-1:0] c,
                                  input logic [NW-1:0] v);
    logic base;
    logic [NW-1:0] care;
    care = ~(c ^ (c + {{(NW-1){1'b0}}, 1'b1}));
    unique case (mode[2:0])
      3'h0: base = (v == c);
      3'h1: base = ((v ^ c) & care) == '0;
      3'h2: base = (v >= c);
      3'h3: base = (v < c);
      3'h4: base = ((v[HW-1:0] & c[NW-1:HW]) == c[HW-1:0]);
      3'h5: base = ((v[NW-1:HW] & c[NW-1:HW]) == c[HW-1:0]);
      default: base = 1'b0;
    endcase
    return base ^ mode[3];
  endfunction : hit_fn

  function automatic logic mode_legal(input logic [3:0] mode);
    return mode inside {tmc_pkg::TMC_MODE_EQ, tmc_pkg::TMC_MODE_NAPOT, tmc_pkg::TMC_MODE_GE,
                        tmc_pkg::TMC_MODE_LT, tmc_pkg::TMC_MODE_MLO, tmc_pkg::TMC_MODE_MHI,
                        tmc_pkg::TMC_MODE_NEQ, tmc_pkg::TMC_MODE_NNAPOT,
                        tmc_pkg::TMC_MODE_NMLO, tmc_pkg::TMC_MODE_NMHI};
  endfunction : mode_legal

  // Match evaluation, one access per cycle
  always_comb begin
    logic [NW-1:0] v;
    logic [NW-1:0] c;
    logic [NW-1:0] szmask;
    logic pen;
    logic [CW-1:0] k;
    v = '0;
    c = '0;
    szmask = '1;
    pen = 1'b0;
    k = '0;
    for (int t = 0; t < NTRIG; t++) begin
      k = st_reg.ctrl[t];
      unique case (PRIV)
        tmc_pkg::TMC_PRIV_M: pen = k[tmc_pkg::TMC_M_BIT];
        tmc_pkg::TMC_PRIV_S: pen = k[tmc_pkg::TMC_S_BIT];
        tmc_pkg::TMC_PRIV_U: pen = k[tmc_pkg::TMC_U_BIT];
        default: pen = 1'b0;
      endcase
      elig[t] = pen && ((k[tmc_pkg::TMC_EXEC_BIT] && OP_EXEC)
                || (k[tmc_pkg::TMC_STORE_BIT] && OP_STORE)
                || (k[tmc_pkg::TMC_LOAD_BIT] && OP_LOAD));
      // Opcode for fetches, data for loads and stores
      v = k[tmc_pkg::TMC_SEL_BIT] ? OP_DATA : OP_ADDR;
      szmask = '1;
      if (k[tmc_pkg::TMC_SEL_BIT]) begin
        unique case (OP_SIZE)
          tmc_pkg::TMC_SIZE_8: szmask = NW'(8'hff);
          tmc_pkg::TMC_SIZE_16: szmask = NW'(16'hffff);
          default: szmask = '1;
        endcase
      end
      c = st_reg.cmp[t] & szmask;
      v = v & szmask;
      raw[t] = OP_VALID && elig[t]
               && hit_fn(k[tmc_pkg::TMC_MODE_LSB +: tmc_pkg::TMC_MODE_W], c, v);
      // A chained predecessor that misses blocks this one
      if (t == 0) begin
        ok[t] = raw[t];
      end else begin
        ok[t] = raw[t] && (!st_reg.ctrl[t-1][tmc_pkg::TMC_CHAIN_BIT] || ok[t-1]);
      end
      ends[t] = ok[t] && !k[tmc_pkg::TMC_CHAIN_BIT];
    end
  end

  assign widx = st_reg.addr[7:3];
  assign wr_ctrl = (st_reg.bus == tmc_pkg::TMC_BUS_WR)
                   && (st_reg.addr[11:8] == tmc_pkg::TMC_TRIG_PAGE)
                   && (int'(widx) < NTRIG) && !st_reg.addr[tmc_pkg::TMC_TRIG_WORD_BIT];
  assign wr_cmp = (st_reg.bus == tmc_pkg::TMC_BUS_WR)
                  && (st_reg.addr[11:8] == tmc_pkg::TMC_TRIG_PAGE)
                  && (int'(widx) < NTRIG) && st_reg.addr[tmc_pkg::TMC_TRIG_WORD_BIT];

  always_comb begin
    logic [CW-1:0] w;
    logic [31:0] rd;
    logic run;
    int below;
    int above;
    int p;
    int n;
    w = '0;
    rd = '0;
    run = 1'b0;
    below = 0;
    above = 0;
    p = 0;
    n = 0;
    st_next = st_reg;
    st_next.fire = 1'b0;
    // Lowest ending trigger reports; every ending trigger marks its hit bit
    for (int t = NTRIG - 1; t >= 0; t--) begin
      if (ends[t]) begin
        st_next.fire = 1'b1;
        st_next.fire_act = st_reg.ctrl[t][tmc_pkg::TMC_ACT_LSB +: tmc_pkg::TMC_ACT_W];
        st_next.fire_idx = IW'(t);
      end
    end
    unique case (st_reg.bus)
      tmc_pkg::TMC_BUS_RD: begin
        // Read data is built one cycle late so a preceding write is seen
        if (st_reg.addr == tmc_pkg::TMC_HIT_OFS) begin
          rd[NTRIG-1:0] = st_reg.hit;
        end else if (st_reg.addr == tmc_pkg::TMC_LAST_OFS) begin
          rd[IW-1:0] = st_reg.fire_idx;
          rd[tmc_pkg::TMC_LAST_ACT_LSB +: 4] = st_reg.fire_act;
        end else if (st_reg.addr[11:8] == tmc_pkg::TMC_TRIG_PAGE && int'(widx) < NTRIG) begin
          if (st_reg.addr[tmc_pkg::TMC_TRIG_WORD_BIT]) begin
            rd[NW-1:0] = st_reg.cmp[widx[IW-1:0]];
          end else begin
            rd[CW-1:0] = st_reg.ctrl[widx[IW-1:0]];
          end
        end
        st_next.hrdata = rd;
        st_next.hready = 1'b1;
        st_next.bus = tmc_pkg::TMC_BUS_IDLE;
      end
      tmc_pkg::TMC_BUS_WR: begin
        st_next.bus = tmc_pkg::TMC_BUS_IDLE;
        if (st_reg.addr == tmc_pkg::TMC_HIT_OFS) begin
          st_next.hit = st_reg.hit & ~HWDATA[NTRIG-1:0];
        end
        if (wr_cmp) begin
          st_next.cmp[widx[IW-1:0]] = HWDATA[NW-1:0];
        end
        for (int t = 0; t < NTRIG; t++) begin
          if (wr_ctrl && int'(widx) == t) begin
            p = (t == 0) ? 0 : t - 1;
            n = (t == NTRIG - 1) ? t : t + 1;
            w = HWDATA[CW-1:0];
            if (w[tmc_pkg::TMC_ACT_LSB +: tmc_pkg::TMC_ACT_W] > tmc_pkg::TMC_ACT_MAX) begin
              w[tmc_pkg::TMC_ACT_LSB +: tmc_pkg::TMC_ACT_W] = '0;
            end
            if (!mode_legal(w[tmc_pkg::TMC_MODE_LSB +: tmc_pkg::TMC_MODE_W])) begin
              w[tmc_pkg::TMC_MODE_LSB +: tmc_pkg::TMC_MODE_W] = tmc_pkg::TMC_MODE_EQ;
            end
            if (!HAS_S) begin
              w[tmc_pkg::TMC_S_BIT] = 1'b0;
            end
            if (!HAS_U) begin
              w[tmc_pkg::TMC_U_BIT] = 1'b0;
            end
            // The last trigger has no successor to chain into
            if (t == NTRIG - 1) begin
              w[tmc_pkg::TMC_CHAIN_BIT] = 1'b0;
            end
            if (!w[tmc_pkg::TMC_DMODE_BIT] && t < NTRIG - 1
                && st_reg.ctrl[n][tmc_pkg::TMC_DMODE_BIT]) begin
              w[tmc_pkg::TMC_CHAIN_BIT] = 1'b0;
            end
            below = 0;
            run = 1'b1;
            for (int j = t - 1; j >= 0; j--) begin
              run = run && st_reg.ctrl[j][tmc_pkg::TMC_CHAIN_BIT];
              below = below + (run ? 1 : 0);
            end
            above = 0;
            run = 1'b1;
            for (int j = t + 1; j < NTRIG; j++) begin
              run = run && st_reg.ctrl[j][tmc_pkg::TMC_CHAIN_BIT];
              above = above + (run ? 1 : 0);
            end
            if (w[tmc_pkg::TMC_CHAIN_BIT] && below + above + 2 > MAX_CHAIN) begin
              w[tmc_pkg::TMC_CHAIN_BIT] = 1'b0;
            end
            // Keep software from silently breaking a running chain
            if (!(w[tmc_pkg::TMC_DMODE_BIT] && t > 0 && !st_reg.ctrl[p][tmc_pkg::TMC_DMODE_BIT]
                  && st_reg.ctrl[p][tmc_pkg::TMC_CHAIN_BIT])) begin
              st_next.ctrl[t] = w;
            end
          end
        end
      end
      default: begin
      end
    endcase
    // New hits win over a same-cycle clear
    st_next.hit = st_next.hit | ends;
    if (st_reg.bus != tmc_pkg::TMC_BUS_RD && HSEL && HREADY && HTRANS[1]) begin
      st_next.addr = HADDR[11:0];
      st_next.bus = HWRITE ? tmc_pkg::TMC_BUS_WR : tmc_pkg::TMC_BUS_RD;
      st_next.hready = HWRITE;
    end
    if (!RST_N) begin
      st_next = '0;
      st_next.bus = tmc_pkg::TMC_BUS_IDLE;
      st_next.hready = 1'b1;
      for (int t = 0; t < NTRIG; t++) begin
        st_next.ctrl[t] = tmc_pkg::TMC_CTRL_RESET;
      end
    end
  end

  always_ff @(posedge CLK) begin
    st_reg <= st_next;
  end

  assign HREADYOUT = st_reg.hready;
  assign HRDATA = st_reg.hrdata;
  assign HRESP = 1'b0;
  assign FIRE = st_reg.fire;
  assign FIRE_ACTION = st_reg.fire_act;
  assign FIRE_INDEX = st_reg.fire_idx;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  property p_act_reset;
    $rose(RST_N) |-> st_reg.ctrl[0][tmc_pkg::TMC_ACT_LSB +: tmc_pkg::TMC_ACT_W] == 4'h0;
  endproperty
  a_act_reset: assert property (p_act_reset) else $error("action not zero after reset");

  property p_chain_block;
    (st_reg.ctrl[0][tmc_pkg::TMC_CHAIN_BIT] && !raw[0]) |-> !ok[1];
  endproperty
  a_chain_block: assert property (p_chain_block) else $error("missed link did not block");

  property p_chain_last;
    st_reg.ctrl[0][tmc_pkg::TMC_CHAIN_BIT] |-> !ends[0]
      && (ends[1] == (raw[0] && raw[1] && !st_reg.ctrl[1][tmc_pkg::TMC_CHAIN_BIT]));
  endproperty
  a_chain_last: assert property (p_chain_last) else $error("chain end decision wrong");

  property p_fire_next;
    ends[0] |=> FIRE && FIRE_INDEX == '0
      && FIRE_ACTION == $past(st_reg.ctrl[0][tmc_pkg::TMC_ACT_LSB +: tmc_pkg::TMC_ACT_W]);
  endproperty
  a_fire_next: assert property (p_fire_next) else $error("fire not reported next cycle");

  // A trigger written with debug-only clear whose successor is debug-only
  property p_dmode_chain;
    (wr_ctrl && int'(widx) < NTRIG - 1 && !HWDATA[tmc_pkg::TMC_DMODE_BIT]
     && st_reg.ctrl[widx[IW-1:0] + IW'(1)][tmc_pkg::TMC_DMODE_BIT])
      |-> !st_next.ctrl[widx[IW-1:0]][tmc_pkg::TMC_CHAIN_BIT];
  endproperty
  a_dmode_chain: assert property (p_dmode_chain) else $error("chain kept into debug trigger");

  property p_dmode_drop;
    (wr_ctrl && widx != 5'h00 && HWDATA[tmc_pkg::TMC_DMODE_BIT]
     && !st_reg.ctrl[widx[IW-1:0] - IW'(1)][tmc_pkg::TMC_DMODE_BIT]
     && st_reg.ctrl[widx[IW-1:0] - IW'(1)][tmc_pkg::TMC_CHAIN_BIT])
      |=> $stable(st_reg.ctrl);
  endproperty
  a_dmode_drop: assert property (p_dmode_drop) else $error("bad debug-only write taken");

  property p_eq_match;
    (OP_VALID && elig[0] && !st_reg.ctrl[0][tmc_pkg::TMC_SEL_BIT]
     && st_reg.ctrl[0][tmc_pkg::TMC_MODE_LSB +: 4] == tmc_pkg::TMC_MODE_EQ)
      |-> raw[0] == (OP_ADDR == st_reg.cmp[0]);
  endproperty
  a_eq_match: assert property (p_eq_match) else $error("equality match wrong");

  property p_ge_match;
    (OP_VALID && elig[0] && !st_reg.ctrl[0][tmc_pkg::TMC_SEL_BIT]
     && st_reg.ctrl[0][tmc_pkg::TMC_MODE_LSB +: 4] == tmc_pkg::TMC_MODE_GE)
      |-> raw[0] == (OP_ADDR >= st_reg.cmp[0]);
  endproperty
  a_ge_match: assert property (p_ge_match) else $error("unsigned ge match wrong");

  property p_lt_match;
    (OP_VALID && elig[0] && !st_reg.ctrl[0][tmc_pkg::TMC_SEL_BIT]
     && st_reg.ctrl[0][tmc_pkg::TMC_MODE_LSB +: 4] == tmc_pkg::TMC_MODE_LT)
      |-> raw[0] == (OP_ADDR < st_reg.cmp[0]);
  endproperty
  a_lt_match: assert property (p_lt_match) else $error("unsigned lt match wrong");

  property p_mmode;
    (PRIV == tmc_pkg::TMC_PRIV_M && !st_reg.ctrl[0][tmc_pkg::TMC_M_BIT]) |-> !raw[0];
  endproperty
  a_mmode: assert property (p_mmode) else $error("match in disabled machine mode");

  property p_no_s;
    !HAS_S |-> !st_reg.ctrl[0][tmc_pkg::TMC_S_BIT];
  endproperty
  a_no_s: assert property (p_no_s) else $error("absent S enable reads one");

  property p_no_u;
    !HAS_U |-> !st_reg.ctrl[0][tmc_pkg::TMC_U_BIT];
  endproperty
  a_no_u: assert property (p_no_u) else $error("absent U enable reads one");

  property p_qual;
    (!(st_reg.ctrl[0][tmc_pkg::TMC_EXEC_BIT] && OP_EXEC)
     && !(st_reg.ctrl[0][tmc_pkg::TMC_STORE_BIT] && OP_STORE)
     && !(st_reg.ctrl[0][tmc_pkg::TMC_LOAD_BIT] && OP_LOAD)) |=> !(FIRE && FIRE_INDEX == '0);
  endproperty
  a_qual: assert property (p_qual) else $error("fired without applicable qualifier");
endmodule : tmc_trigger_match

// ==== trigger_match_chain_test.sv ====
// Self-checking bench for the trigger match and chain block.
// Assumes one AHB-Lite slave and the hart model on the access port.
`timescale 1ns/1ps
module trigger_match_chain_test;
  localparam logic [2:0] EX = 3'b001;
  localparam logic [2:0] ST = 3'b010;
  localparam logic [2:0] LD = 3'b100;
  localparam logic [1:0] PM = tmc_pkg::TMC_PRIV_M;
  localparam logic [1:0] PS = tmc_pkg::TMC_PRIV_S;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic op_valid;
  logic [2:0] op_kind;
  logic [1:0] op_priv;
  logic [1:0] op_size;
  logic [31:0] op_addr;
  logic [31:0] op_data;
  logic fire;
  logic [3:0] fire_action;
  logic [1:0] fire_index;
  logic [31:0] rd;
  int errors = 0;
  int cmp_count = 0;

  always #10 clk = ~clk;

  // Short chain cap and no user mode so both legalizations show
  tmc_trigger_match #(.HAS_U(1'b0), .MAX_CHAIN(3)) DUT (
    .CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp), .OP_VALID(op_valid),
    .OP_EXEC(op_kind[0]), .OP_STORE(op_kind[1]), .OP_LOAD(op_kind[2]), .PRIV(op_priv),
    .OP_ADDR(op_addr), .OP_DATA(op_data), .OP_SIZE(op_size), .FIRE(fire),
    .FIRE_ACTION(fire_action), .FIRE_INDEX(fire_index));

  tmc_hart_model hart (.clk(clk), .op_valid(op_valid), .op_kind(op_kind),
    .op_priv(op_priv), .op_addr(op_addr), .op_data(op_data), .op_size(op_size));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Ready is read before the edge, so the sample never races the slave
  task automatic wait_rdy;
    logic rdy;
    do begin
      @(negedge clk);
      rdy = hreadyout;
      rd = hrdata;
      @(posedge clk);
    end while (rdy !== 1'b1);
  endtask : wait_rdy

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
  endtask : ahb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask : rdchk

  // Control word: p is {U,S,M}, q is {load,store,execute}
  function automatic logic [31:0] cw(input logic [3:0] act, input logic ch, input logic [3:0] md,
                                     input logic [2:0] p, input logic [2:0] q, input logic dm,
                                     input logic sl);
    return {15'h0, sl, dm, q, p, md, ch, act};
  endfunction : cw

  task automatic acc(input logic [2:0] k, input logic [1:0] p, input logic [31:0] a,
                     input logic [31:0] d, input logic [1:0] s, input logic e,
                     input logic [1:0] idx, input logic [3:0] act);
    hart.access(k, p, a, d, s);
    #1;
    chk({31'h0, fire}, {31'h0, e});
    if (e) begin
      chk({30'h0, fire_index}, {30'h0, idx});
      chk({28'h0, fire_action}, {28'h0, act});
    end
    @(posedge clk);
  endtask : acc

  task automatic mt(input logic [3:0] md, input logic [31:0] c, input logic [31:0] a,
                    input logic e);
    wr(32'h100, cw(4'h1, 1'b0, md, 3'b001, EX, 1'b0, 1'b0));
    wr(32'h104, c);
    acc(EX, PM, a, 32'h0, 2'h0, e, 2'h0, 4'h1);
  endtask : mt

  task automatic conclude;
    $display("Comparisons %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    conclude();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int t = 0; t < 4; t++) begin
      rdchk(32'h100 + 32'(8 * t), 32'h0);
    end
    rdchk(32'h0, 32'h0);
    wr(32'h100, cw(4'hf, 1'b0, 4'h0, 3'b000, 3'b000, 1'b0, 1'b0));
    rdchk(32'h100, 32'h0);
    wr(32'h100, cw(4'h1, 1'b0, 4'h6, 3'b111, EX, 1'b0, 1'b0));
    rdchk(32'h100, cw(4'h1, 1'b0, 4'h0, 3'b011, EX, 1'b0, 1'b0));
    mt(4'h0, 32'h1000, 32'h1000, 1'b1);
    mt(4'h0, 32'h1000, 32'h1004, 1'b0);
    mt(4'h1, 32'h100f, 32'h101f, 1'b1);
    mt(4'h1, 32'h100f, 32'h1020, 1'b0);
    mt(4'h2, 32'h2000, 32'h2000, 1'b1);
    mt(4'h2, 32'h2000, 32'h1fff, 1'b0);
    mt(4'h3, 32'h2000, 32'h1fff, 1'b1);
    mt(4'h3, 32'h2000, 32'h2000, 1'b0);
    mt(4'h4, 32'h00ff0034, 32'habcd1234, 1'b1);
    mt(4'h4, 32'h00ff0034, 32'habcd1235, 1'b0);
    mt(4'h5, 32'hff001200, 32'h12ab0000, 1'b1);
    mt(4'h5, 32'hff001200, 32'h13ab0000, 1'b0);
    mt(4'h8, 32'h1000, 32'h1000, 1'b0);
    mt(4'h8, 32'h1000, 32'h1004, 1'b1);
    mt(4'h9, 32'h100f, 32'h1020, 1'b1);
    mt(4'hc, 32'h00ff0034, 32'habcd1234, 1'b0);
    mt(4'hd, 32'hff001200, 32'h13ab0000, 1'b1);
    wr(32'h104, 32'h40);
    acc(EX, PS, 32'h40, 32'h0, 2'h0, 1'b0, 2'h0, 4'h0);
    acc(LD, PM, 32'h40, 32'h0, 2'h0, 1'b0, 2'h0, 4'h0);
    wr(32'h100, cw(4'h1, 1'b0, 4'h0, 3'b110, ST, 1'b0, 1'b0));
    acc(ST, PS, 32'h40, 32'h0, 2'h0, 1'b1, 2'h0, 4'h1);
    acc(ST, PM, 32'h40, 32'h0, 2'h0, 1'b0, 2'h0, 4'h0);
    acc(ST, tmc_pkg::TMC_PRIV_U, 32'h40, 32'h0, 2'h0, 1'b0, 2'h0, 4'h0);
    wr(32'h100, cw(4'h1, 1'b0, 4'h0, 3'b001, LD, 1'b0, 1'b1));
    wr(32'h104, 32'h12345678);
    acc(LD, PM, 32'h0, 32'haaaaaa78, tmc_pkg::TMC_SIZE_8, 1'b1, 2'h0, 4'h1);
    acc(LD, PM, 32'h0, 32'haaaa5678, tmc_pkg::TMC_SIZE_16, 1'b1, 2'h0, 4'h1);
    acc(LD, PM, 32'h0, 32'haaaaaa78, 2'h0, 1'b0, 2'h0, 4'h0);
    acc(LD, PM, 32'h0, 32'h12345678, 2'h0, 1'b1, 2'h0, 4'h1);
    rdchk(32'h0, 32'h1);
    wr(32'h0, 32'h1);
    rdchk(32'h0, 32'h0);
    wr(32'h100, cw(4'h1, 1'b1, 4'h0, 3'b001, EX, 1'b0, 1'b0));
    wr(32'h104, 32'h2000);
    wr(32'h108, cw(4'h0, 1'b0, 4'h0, 3'b001, EX, 1'b0, 1'b1));
    wr(32'h10c, 32'h13);
    acc(EX, PM, 32'h2000, 32'h13, 2'h0, 1'b1, 2'h1, 4'h0);
    acc(EX, PM, 32'h2000, 32'h14, 2'h0, 1'b0, 2'h0, 4'h0);
    acc(EX, PM, 32'h2004, 32'h13, 2'h0, 1'b0, 2'h0, 4'h0);
    rdchk(32'h4, 32'h1);
    rdchk(32'h0, 32'h2);
    wr(32'h108, cw(4'h0, 1'b1, 4'h0, 3'b001, EX, 1'b0, 1'b1));
    wr(32'h110, cw(4'h0, 1'b1, 4'h0, 3'b001, EX, 1'b0, 1'b0));
    rdchk(32'h110, cw(4'h0, 1'b0, 4'h0, 3'b001, EX, 1'b0, 1'b0));
    wr(32'h100, cw(4'h0, 1'b0, 4'h0, 3'b001, EX, 1'b0, 1'b0));
    wr(32'h118, cw(4'h0, 1'b0, 4'h0, 3'b001, EX, 1'b1, 1'b0));
    rdchk(32'h108, cw(4'h0, 1'b1, 4'h0, 3'b001, EX, 1'b0, 1'b1));
    wr(32'h110, cw(4'h0, 1'b1, 4'h0, 3'b001, EX, 1'b0, 1'b0));
    rdchk(32'h110, cw(4'h0, 1'b0, 4'h0, 3'b001, EX, 1'b0, 1'b0));
    wr(32'h110, cw(4'h1, 1'b0, 4'h0, 3'b001, EX, 1'b1, 1'b0));
    rdchk(32'h110, cw(4'h0, 1'b0, 4'h0, 3'b001, EX, 1'b0, 1'b0));
    wr(32'h8, 32'hffffffff);
    rdchk(32'h8, 32'h0);
    conclude();
  end
endmodule : trigger_match_chain_test
